// [logic/odl_loader.sv]
// Serial input logic of an eight-channel 8-bit DAC.
// Assumes the pins come from another domain; ref_clk samples them.
// Assumes sclk stays high and low for three ref_clk periods at least.
// Assumes select stays high for three ref_clk periods between frames.
`timescale 1ns/10ps
`include "odl_defs.svh"
module odl_loader #(
  parameter int CHANNELS = `ODL_CHANNELS,
  parameter int WORD_W = `ODL_WORD_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic midscale_preset_n,
  input wire logic power_down_n,
  output logic [CHANNELS*`ODL_CODE_W-1:0] dac_codes,
  output logic [CHANNELS-1:0] channel_loaded,
  output logic outputs_active
);
  odl_pkg::odl_pins_type pins_async;
  odl_pkg::odl_pins_type pins_sync;
  odl_pkg::odl_pins_type pins_idle;
  odl_pkg::odl_pins_type pins_prev_r;
  odl_pkg::odl_word_type word;
  odl_pkg::odl_state_type state_r;
  logic [1:0] ctl_sync;
  logic [WORD_W-1:0] shift_r;
  logic [`ODL_CODE_W-1:0] code_r [CHANNELS];
  logic [CHANNELS-1:0] load_sel;
  logic [CHANNELS-1:0] loaded_r;
  logic sclk_rise;
  logic commit;
  logic preset_n;

  // One-hot decode of channel index
  function automatic logic [CHANNELS-1:0] odl_decode(
    input logic [`ODL_ADDR_W-1:0] addr
  );
    logic [CHANNELS-1:0] hot;
    hot = '0;
    if (addr == 3'h0)
      hot[0] = 1'b1;
    else if (addr == 3'h1)
      hot[1] = 1'b1;
    else if (addr == 3'h2)
      hot[2] = 1'b1;
    else if (addr == 3'h3)
      hot[3] = 1'b1;
    else if (addr == 3'h4)
      hot[4] = 1'b1;
    else if (addr == 3'h5)
      hot[5] = 1'b1;
    else if (addr == 3'h6)
      hot[6] = 1'b1;
    else if (addr == 3'h7)
      hot[7] = 1'b1;
    return hot;
  endfunction

  assign pins_async.select_n = select_n;
  assign pins_async.sclk = sclk;
  assign pins_async.sdata = serial_data_in;
  assign pins_idle.select_n = 1'b1;
  assign pins_idle.sclk = 1'b1;
  assign pins_idle.sdata = 1'b0;

  // Pins cross into ref_clk here; nothing reads stage one
  odl_sync #(.WIDTH(3)) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(pins_async),
    .reset_value(pins_idle),
    .sync_out(pins_sync)
  );

  // Preset and power-down levels share one synchroniser
  odl_sync #(.WIDTH(2)) u_ctl_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in({midscale_preset_n, power_down_n}),
    .reset_value(2'h3),
    .sync_out(ctl_sync)
  );
  assign preset_n = ctl_sync[1];

  // Edge detection on synchronised copies only
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pins_prev_r <= pins_idle;
    else
      pins_prev_r <= pins_sync;
  end

  assign sclk_rise = pins_sync.sclk & ~pins_prev_r.sclk;
  // Select rising edge commits
  // Only an open frame may commit, so reset never loads
  always_comb
  begin
    commit = 1'b0;
    case (state_r)
      odl_pkg::ODL_IDLE:
        commit = 1'b0;
      odl_pkg::ODL_SHIFT:
        commit = pins_sync.select_n;
      default:
        commit = 1'b0;
    endcase
  end

  // Tracks whether a frame is open
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_r <= odl_pkg::ODL_IDLE;
    else
      case (state_r)
        odl_pkg::ODL_IDLE:
          if (!pins_sync.select_n)
            state_r <= odl_pkg::ODL_SHIFT;
        odl_pkg::ODL_SHIFT:
          if (pins_sync.select_n)
            state_r <= odl_pkg::ODL_IDLE;
        default:
          state_r <= odl_pkg::ODL_IDLE;
      endcase
  end

  // Shift one bit per rising clock
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      shift_r <= '0;
    else if (!pins_sync.select_n && sclk_rise)
      // Oldest bit falls off the top
      shift_r <= {shift_r[WORD_W-2:0], pins_sync.sdata};
  end

  // Address above, code below, MSB first
  // Surplus bits between address and code of a wider shifter never reach the word
  always_comb
  begin
    word.addr = shift_r[WORD_W-1 -: `ODL_ADDR_W];
    word.code = shift_r[`ODL_CODE_W-1:0];
  end
  // Index equals address, channel number is index plus one
  assign load_sel = commit ? odl_decode(word.addr) : '0;

  // Channel registers, one per DAC
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      always_ff @(posedge ref_clk)
      begin
        if (reset || !preset_n)
          code_r[ch] <= `ODL_MIDSCALE;
        else if (load_sel[ch])
          code_r[ch] <= word.code;
      end
      assign dac_codes[ch*`ODL_CODE_W +: `ODL_CODE_W] = code_r[ch];
    end
  endgenerate

  // One-cycle pulse per channel update
  // Preset wins over a load that falls in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      loaded_r <= '0;
    else
      loaded_r <= preset_n ? load_sel : '0;
  end
  assign channel_loaded = loaded_r;

  // Shutdown keeps codes; only the output state follows the pin
  assign outputs_active = ctl_sync[0];
endmodule // odl_loader

// [common/odl_defs.svh]
// Constants for the octal DAC serial loader.
// Assumes inclusion by bare name from design and bench files.
`ifndef ODL_DEFS_SVH
`define ODL_DEFS_SVH
`define ODL_ADDR_W 3
`define ODL_CODE_W 8
`define ODL_WORD_W 11
`define ODL_CHANNELS 8
`define ODL_MIDSCALE 8'h80
`define ODL_SYNC_STAGES 2
`endif

// [common/odl_pkg.sv]
// Types for the octal DAC serial loader.
// Assumes odl_defs.svh is on the include path.
`include "odl_defs.svh"
package odl_pkg;
  typedef struct packed {
    logic [`ODL_ADDR_W-1:0] addr;
    logic [`ODL_CODE_W-1:0] code;
  } odl_word_type;
  typedef struct packed {
    logic select_n;
    logic sclk;
    logic sdata;
  } odl_pins_type;
  typedef enum logic [0:0] {
    ODL_IDLE = 1'b0,
    ODL_SHIFT = 1'b1
  } odl_state_type;
endpackage

// [logic/odl_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes the first stage is read only by the second stage.
`timescale 1ns/10ps
`include "odl_defs.svh"
module odl_sync #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_value,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1_r <= reset_value;
      stage2_r <= reset_value;
    end
    else
    begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end
  assign sync_out = stage2_r;
endmodule // odl_sync

// [tb/odl_loader_assertions.sv]
// Port checker for odl_loader.
// Assumes the bind below and pins from the host model.
`timescale 1ns/10ps
module odl_chk #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic select_n,
  input wire logic midscale_preset_n,
  input wire logic [CHANNELS*8-1:0] dac_codes,
  input wire logic [CHANNELS-1:0] channel_loaded
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_cs_up; $rose(select_n) ##0 midscale_preset_n; endsequence
  sequence s_quiet; (select_n && midscale_preset_n)[*8]; endsequence
  chk_one_chan: assert property ($onehot0(channel_loaded))
    else $error("two loads");
  chk_pulse_one: assert property (|channel_loaded |=> !channel_loaded)
    else $error("long pulse");
  chk_load_rise: assert property (s_cs_up |-> ##[2:6] |channel_loaded)
    else $error("no load");
  chk_low_none: assert property ((!select_n)[*6] |-> !channel_loaded)
    else $error("early load");
  chk_idle_none: assert property (select_n[*8] |-> !channel_loaded)
    else $error("idle load");
  chk_idle_hold: assert property (s_quiet |=> $stable(dac_codes))
    else $error("idle change");
  chk_preset_mid:
    assert property ((!midscale_preset_n)[*4] |->
    dac_codes == {CHANNELS{8'h80}}) else $error("no preset");
  chk_reset_mid:
    assert property (disable iff (1'b0) reset |=>
    dac_codes == {CHANNELS{8'h80}} && !channel_loaded)
    else $error("bad reset");
endmodule // odl_chk
bind odl_loader odl_chk #(.CHANNELS(CHANNELS)) chk_u (.*);

// [tb/odl_host.sv]
// Host model driving the three serial pins.
// Assumes one caller at a time.
`timescale 1ns/10ps
module odl_host (
  output logic select_n = 1'b1,
  output logic sclk = 1'b1,
  output logic serial_data_in = 1'b0
);
  task automatic send(input logic [15:0] w, input int n);
    select_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      serial_data_in = w[i];
      #80 sclk = 1'b1;
      #80;
    end
    select_n = 1'b1;
    // Released line must not show a stale bit
    serial_data_in = ~serial_data_in;
  endtask
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b0;
      serial_data_in = 1'($urandom);
      #80 sclk = 1'b1;
      #80;
    end
  endtask
endmodule // odl_host

// [tb/tb_octal_dac_serial_loader.sv]
// Bench for odl_loader driven by odl_host.
// Assumes odl_chk is bound to the design.
`timescale 1ns/10ps
module tb_octal_dac_serial_loader;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic midscale_preset_n = 1'b1;
  logic power_down_n = 1'b1;
  logic outputs_active;
  logic [63:0] exp_codes = {8{8'h80}};
  wire logic select_n, sclk, serial_data_in;
  logic [63:0] dac_codes;
  logic [7:0] channel_loaded, v;
  logic [10:0] exp_q[$], e, s;
  int error_cnt = 0;
  int n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  odl_host host_u (.*);
  odl_loader dut_u (.*);
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    n_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge ref_clk)
    if (channel_loaded !== 8'h00)
    begin
      e = exp_q.pop_front();
      exp_codes[e[10:8]*8 +: 8] = e[7:0];
      chk(channel_loaded, 8'h01 << e[10:8]);
      chk(dac_codes, exp_codes);
    end
  initial
  begin
    void'($urandom(6));
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    chk(dac_codes, {8{8'h80}});
    chk(outputs_active, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($urandom);
      exp_q.push_back({i[2:0], v});
      #1 host_u.send({5'($urandom), i[2:0], v}, i[3] ? 16 : 11);
      repeat (10) @(posedge ref_clk);
    end
    #1 host_u.idle_clocks(12);
    repeat (10) @(posedge ref_clk);
    // Short frame: older shift bits supply the address
    s = {v[7:5], 8'($urandom)};
    exp_q.push_back(s);
    #1 host_u.send({8'h00, s[7:0]}, 8);
    repeat (10) @(posedge ref_clk);
    #1 power_down_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(outputs_active, 1'b0);
    chk(dac_codes, exp_codes);
    power_down_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(outputs_active, 1'b1);
    midscale_preset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk(dac_codes, {8{8'h80}});
    midscale_preset_n = 1'b1;
    exp_codes = {8{8'h80}};
    chk(exp_q.size(), 0);
    end_sim();
  end
  initial
  begin
    #200000 error_cnt++;
    end_sim();
  end
endmodule // tb_octal_dac_serial_loader
